// ===== hdl/qtic_pkg.sv
// Purpose: Constants for the Q-channel trim and interleave control register bank.
// Assumes: APB slave, 32-bit data, printed register indices times four give byte addresses.
// Notes: All registers are write-only; reads return zero.
package qtic_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [3:0] QTIC_IDX_OFFSET = 4'ha;
    localparam logic [3:0] QTIC_IDX_GAIN = 4'hb;
    localparam logic [3:0] QTIC_IDX_ILV = 4'hd;
    localparam logic [7:0] QTIC_ADDR_OFFSET = {2'h0, QTIC_IDX_OFFSET, 2'h0};
    localparam logic [7:0] QTIC_ADDR_GAIN = {2'h0, QTIC_IDX_GAIN, 2'h0};
    localparam logic [7:0] QTIC_ADDR_ILV = {2'h0, QTIC_IDX_ILV, 2'h0};
    localparam int QTIC_ADDR_W = 8;
    localparam int QTIC_REG_W = 16;
    // ****************************************************************
    // Reset values and fields
    // ****************************************************************
    localparam logic [15:0] QTIC_RST_OFFSET = 16'h007f;
    localparam logic [15:0] QTIC_RST_GAIN = 16'h807f;
    localparam logic [15:0] QTIC_RST_ILV = 16'h3fff;
    localparam int QTIC_OFS_MAG_LSB = 8;
    localparam int QTIC_OFS_SIGN_BIT = 7;
    localparam int QTIC_GAIN_LSB = 7;
    localparam int QTIC_ILV_EN_BIT = 15;
    localparam int QTIC_ILV_ACP_BIT = 14;
    localparam logic [8:0] QTIC_GAIN_MID = 9'h100;
    // Analog meaning of the codes, for downstream trim converters.
    localparam int QTIC_OFS_FULL_UV = 45000;
    localparam int QTIC_FS_MIN_MV = 560;
    localparam int QTIC_FS_NOM_MV = 700;
    localparam int QTIC_FS_MAX_MV = 840;
endpackage : qtic_pkg

// ===== hdl/qtic_trim_reg.sv
// Purpose: One write-only 16-bit trim register with a reset value.
// Assumes: Write strobe is a single-cycle pulse.
// Notes: Shared by all three registers of the bank.
`timescale 1ns/100ps
module qtic_trim_reg
    import qtic_pkg::*;
#(
    parameter logic [15:0] RST_VAL = 16'h0000
)
(
    input wire logic clk, // Clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic wrEn, // Write strobe.
    input wire logic [15:0] wrData, // Data to store.
    output logic [15:0] value // Stored value.
);
    typedef struct packed {
        logic [15:0] value;
    } qtic_reg_state_t;

    qtic_reg_state_t state;
    qtic_reg_state_t next_state;

    always_comb
    begin
        next_state = state;
        if (wrEn)
        begin
            next_state.value = wrData;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state.value <= RST_VAL;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign value = state.value;
endmodule : qtic_trim_reg

// ===== hdl/qtic_ctrl.sv
// Purpose: Q-channel offset and gain trim plus interleave control registers on APB.
// Assumes: Single clock at 100 MHz; the analog trim circuits consume the decoded outputs.
// Notes: Registers are write-only; reads complete with zero data, and with no error only at a mapped address.
//
// Overview of operation
// R01: Offset magnitude taken from bits 15:8.
// R02: Code 00h zero, FFh about 45 mV.
// R03: Bit 7 selects negative offset direction.
// R04: Offset magnitude resets to zero.
// R05: Software writes ones to unused bits.
// R06: Gain code taken from bits 15:7.
// R07: Gain codes span 560 to 840 mV.
// R08: Software keeps gain code in recommended range.
// R09: New gain applies without recalibration.
// R10: Gain code resets to mid code.
// R11: Interleave bit selects dual-edge sampling.
// R12: Auto phase ignores manual delays.
// R13: Manual phase uses coarse/fine delay values.
// R14: Software should prefer automatic phase.
// R15: Interleave and auto phase reset cleared.
// R16: Registers are write-only, read zero.
`timescale 1ns/100ps
module qtic_ctrl
    import qtic_pkg::*;
(
    input wire logic clk, // Clock, 100 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [QTIC_ADDR_W-1:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data, always zero.
    output logic pready, // APB ready, always high.
    output logic pslverr, // APB error, high for unmapped address.
    output logic [7:0] offsetMagnitude, // Q offset magnitude code.
    output logic offsetNegative, // Q offset direction, high for negative.
    output logic [8:0] gainCode, // Q full-scale adjust code.
    output logic gainUpdate, // Pulse when a new gain code is applied.
    output logic interleave_enable, // Dual-edge interleaved sampling.
    output logic auto_phase_align, // Automatic sampling phase alignment.
    output logic manualDelayEnable // Manual coarse/fine delay in use.
);
    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic access;
    logic wrOffset;
    logic wrGain;
    logic wrIlv;
    logic mapped;
    logic [15:0] offsetReg;
    logic [15:0] gainReg;
    logic [15:0] ilvReg;

    assign access = psel && penable;
    assign mapped = (paddr == QTIC_ADDR_OFFSET) || (paddr == QTIC_ADDR_GAIN)
        || (paddr == QTIC_ADDR_ILV);
    assign wrOffset = access && pwrite && (paddr == QTIC_ADDR_OFFSET);
    assign wrGain = access && pwrite && (paddr == QTIC_ADDR_GAIN);
    assign wrIlv = access && pwrite && (paddr == QTIC_ADDR_ILV);
    // Zero-wait slave; nothing can be read back, so data is constant zero.
    assign pready = 1'b1;
    assign prdata = 32'h0000_0000; // R16
    assign pslverr = access && !mapped;

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Unused low bits are stored as written; software is expected to write ones there.
    qtic_trim_reg #(.RST_VAL(QTIC_RST_OFFSET)) uOffset ( // R04
        .clk(clk),
        .rst_n(rst_n),
        .wrEn(wrOffset),
        .wrData(pwdata[15:0]),
        .value(offsetReg)
    );

    qtic_trim_reg #(.RST_VAL(QTIC_RST_GAIN)) uGain ( // R10
        .clk(clk),
        .rst_n(rst_n),
        .wrEn(wrGain),
        .wrData(pwdata[15:0]),
        .value(gainReg)
    );

    qtic_trim_reg #(.RST_VAL(QTIC_RST_ILV)) uIlv ( // R15
        .clk(clk),
        .rst_n(rst_n),
        .wrEn(wrIlv),
        .wrData(pwdata[15:0]),
        .value(ilvReg)
    );

    // ****************************************************************
    // Decoded controls
    // ****************************************************************
    typedef struct packed {
        logic gainUpdate;
    } qtic_ctrl_state_t;

    qtic_ctrl_state_t state;
    qtic_ctrl_state_t next_state;

    // Gain takes effect directly; the pulse only lets the trim DAC latch, no recal is started.
    always_comb
    begin
        next_state = state;
        next_state.gainUpdate = wrGain; // R09
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign offsetMagnitude = offsetReg[QTIC_OFS_MAG_LSB +: 8]; // R01 R02
    assign offsetNegative = offsetReg[QTIC_OFS_SIGN_BIT]; // R03
    assign gainCode = gainReg[QTIC_GAIN_LSB +: 9]; // R06 R07
    assign gainUpdate = state.gainUpdate;
    assign interleave_enable = ilvReg[QTIC_ILV_EN_BIT]; // R11
    assign auto_phase_align = ilvReg[QTIC_ILV_ACP_BIT]; // R12
    assign manualDelayEnable = !ilvReg[QTIC_ILV_ACP_BIT]; // R13

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_OFS_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // R01
        wrOffset |=> offsetMagnitude == $past(pwdata[15:8]))
        else $error("Offset magnitude did not follow the write.");
    AST_OFS_SIGN: assert property (@(posedge clk) disable iff (!rst_n) // R03
        wrOffset |=> offsetNegative == $past(pwdata[7]))
        else $error("Offset sign did not follow the write.");
    AST_OFS_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // R02
        !wrOffset |=> $stable(offsetMagnitude))
        else $error("Offset magnitude changed without a write.");
    AST_GAIN_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // R06
        wrGain |=> gainCode == $past(pwdata[15:7]) && gainUpdate)
        else $error("Gain code or update pulse wrong after write.");
    AST_GAIN_PULSE: assert property (@(posedge clk) disable iff (!rst_n) // R09
        gainUpdate |=> !gainUpdate || $past(wrGain))
        else $error("Gain update pulse stretched.");
    AST_ILV_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // R11
        wrIlv |=> interleave_enable == $past(pwdata[15]))
        else $error("Interleave enable did not follow the write.");
    AST_PHASE_EXCL: assert property (@(posedge clk) disable iff (!rst_n) // R12
        auto_phase_align != manualDelayEnable)
        else $error("Auto and manual phase both active or both idle.");
    AST_PHASE_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // R13
        wrIlv |=> manualDelayEnable == !$past(pwdata[14]))
        else $error("Manual delay select did not follow the write.");
    AST_AUTO_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // R12
        wrIlv |=> auto_phase_align == $past(pwdata[14]))
        else $error("Auto phase select did not follow the write.");
    AST_READ_ZERO: assert property (@(posedge clk) disable iff (!rst_n) // R16
        (access && !pwrite) |-> prdata == 32'h0000_0000)
        else $error("Write-only register returned data.");
    AST_GAIN_MID_RST: assert property (@(posedge clk) // R10
        $rose(rst_n) |-> gainCode == QTIC_GAIN_MID && !interleave_enable
            && offsetMagnitude == 8'h00)
        else $error("Reset values wrong after reset release.");
endmodule : qtic_ctrl

// ===== testbench/tb.sv
// Purpose: Self-checking bench for the Q trim and interleave control bank.
// Assumes: Zero-wait APB slave; reads of mapped registers return zero.
// Notes: Stimulus mixes fixed corner codes with xorshift random codes.
`timescale 1ns/100ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb
    import qtic_pkg::*;
;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [31:0] seed = 32'h841c;
    logic [7:0] offsetMagnitude;
    logic [8:0] gainCode;
    logic offsetNegative, gainUpdate, interleave_enable, auto_phase_align, manualDelayEnable;
    logic [15:0] sh [3];
    logic [20:0] outs;
    logic [17:0] corner [11] = '{18'h0007f, 18'h0ff7f, 18'h0ffff, 18'h1007f, 18'h1ffff,
        18'h1607f, 18'h1e07f, 18'h2ffff, 18'h27fff, 18'h2bfff, 18'h23fff};
    logic [7:0] bad [3] = '{8'h30, 8'ha8, 8'h00};
    int n_mismatch, samples_checked, cycles;
    qtic_ctrl i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .offsetMagnitude(offsetMagnitude), .offsetNegative(offsetNegative),
        .gainCode(gainCode), .gainUpdate(gainUpdate), .interleave_enable(interleave_enable),
        .auto_phase_align(auto_phase_align), .manualDelayEnable(manualDelayEnable));
    assign outs = {offsetMagnitude, offsetNegative, gainCode, interleave_enable,
        auto_phase_align, manualDelayEnable};
    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift
    function automatic logic [20:0] exp_out(input logic [15:0] o, g, d);
        return {o[15:8], o[7], g[15:7], d[15], d[14], ~d[14]};
    endfunction : exp_out
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr_reg(input logic [1:0] sel, input logic [15:0] v);
        logic [7:0] a;
        logic [31:0] t;
        a = (sel == 2'd0) ? QTIC_ADDR_OFFSET : (sel == 2'd1) ? QTIC_ADDR_GAIN : QTIC_ADDR_ILV;
        t = xorshift();
        apb(1'b1, a, {t[31:16], v});
        sh[sel] = v;
        #1;
        `CHK(outs, exp_out(sh[0], sh[1], sh[2]))
        `CHK(err, 1'b0)
        `CHK(gainUpdate, (sel == 2'd1))
        apb(1'b0, a, 32'h0);
        #1;
        `CHK({err, rd}, 33'h0)
        `CHK(gainUpdate, 1'b0)
    endtask : wr_reg
    task automatic chk_reset();
        sh = '{QTIC_RST_OFFSET, QTIC_RST_GAIN, QTIC_RST_ILV};
        `CHK(outs, exp_out(sh[0], sh[1], sh[2]))
        `CHK({gainUpdate, pready, pslverr, prdata}, 35'h200000000)
    endtask : chk_reset
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    // ****************************************************************
    // Clock, timeout and main sequence
    // ****************************************************************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial
    begin
        logic [31:0] t;
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk_reset();
        foreach (corner[i])
            wr_reg(corner[i][17:16], corner[i][15:0]);
        repeat (30)
        begin
            t = xorshift();
            wr_reg(2'(t[17:16] % 3), (t[17:16] % 3 == 2) ? {t[15:14], 14'h3fff}
                : {t[15:7], 7'h7f});
        end
        foreach (bad[i])
        begin
            apb(1'b1, bad[i], 32'hffffffff);
            #1;
            `CHK(err, 1'b1)
            `CHK(outs, exp_out(sh[0], sh[1], sh[2]))
        end
        wr_reg(2'd1, 16'hffff);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        #1;
        chk_reset();
        @(posedge clk);
        rst_n <= 1'b1;
        wr_reg(2'd2, 16'hbfff);
        wr_reg(2'd2, 16'h7fff);
        tally_and_finish();
    end
endmodule : tb
